// File: sim/svm_cmp_model.sv
// analog supply comparator stand-in driven by a supply level in millivolts
`timescale 1ns/10ps
`default_nettype none
module svm_cmp_model (
  input  wire logic        enable_in,
  input  wire logic        threshold_in,
  input  wire logic [11:0] supply_mv_in,
  output logic             comparator_out
);
  // ===========================================================
  // trip comparison
  // powered-down circuit reads high, so software never sees a false low
  // trip and power-down
  assign comparator_out = !enable_in || (supply_mv_in >= (threshold_in ? 12'hBFE : 12'hAE6));
endmodule
`default_nettype wire

// File: sim/svm_top_tb_top.sv
// self-checking testbench for the supply monitor block
`timescale 1ns/10ps
`default_nettype none
module svm_top_tb_top
  import svm_pkg::*;
;
  logic        clk, rst, hsel, hwrite, cmp, en, tp, flag, irq, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] mv;
  logic [15:0] lfsr_q;
  logic        c;
  int          err_count, checks_done;

  svm_top svm_top_i (.ref_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .comparator_in(cmp), .monitor_enable_out(en), .threshold_select_out(tp),
    .low_supply_flag_out(flag), .irq_out(irq));
  svm_cmp_model svm_cmp_model_i (.enable_in(en), .threshold_in(tp), .supply_mv_in(mv),
    .comparator_out(cmp));

  // ===========================================================
  // helpers
  function automatic logic exp_cmp(input logic t, input logic [11:0] v);
    return v >= (t ? 12'hBFE : 12'hAE6);
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single transfer at the current hsize; waits on hready, the watchdog cuts a hang
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= SVM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, SVM_HRESP_OKAY}, "bus response");
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0);
    chk(r, e, m);
  endtask
  // two synchroniser edges plus the flag edge, with margin
  task automatic setmv(input logic [11:0] v);
    @(posedge clk);
    mv <= v;
    repeat (5) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ===========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end

  // ===========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SVM_HSIZE_WORD;
    hwdata = 32'h0;
    mv = 12'hCE4;
    lfsr_q = 16'h0010;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({28'h0, en, tp, flag, irq}, 32'h0, "reset outputs");
    rd(SVM_CTRL_ADDR, 32'h8, "ctrl reset");
    rd(SVM_IMSK_ADDR, 32'h0, "mask reset");
    rd(32'hFFFF044C, 32'h0, "unmapped read");
    // reserved upper bits written high must not stick
    xfer(1'b1, SVM_CTRL_ADDR, 32'hFFFF0002);
    rd(SVM_CTRL_ADDR, 32'hA, "enable only");
    xfer(1'b1, SVM_CTRL_ADDR, 32'h6);
    @(negedge clk);
    chk({30'h0, en, tp}, 32'h3, "enable and trip pins");
    rd(SVM_ISTS_ADDR, 32'h0, "status idle");
    setmv(12'hB54);
    rd(SVM_CTRL_ADDR, 32'h7, "low at high trip");
    xfer(1'b1, SVM_CTRL_ADDR, 32'h7);
    rd(SVM_CTRL_ADDR, 32'h7, "clear refused while low");
    xfer(1'b1, SVM_CTRL_ADDR, 32'h6);
    rd(SVM_CTRL_ADDR, 32'h7, "zero write keeps flag");
    // clear launched right behind the rise, no timeout may block it
    @(posedge clk);
    mv <= 12'hCE4;
    xfer(1'b1, SVM_CTRL_ADDR, 32'h7);
    rd(SVM_CTRL_ADDR, 32'hE, "prompt clear");
    // masked interrupt path
    xfer(1'b1, SVM_IMSK_ADDR, 32'h1);
    rd(SVM_ISTS_ADDR, 32'h3, "events so far");
    setmv(12'hA8C);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(SVM_ISTS_ADDR, 32'h1, "low event");
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq after read");
    setmv(12'hA8C);
    rd(SVM_ISTS_ADDR, 32'h0, "no repeat while low");
    chk({31'h0, irq}, 32'h0, "irq quiet while low");
    // powered down circuit reads good supply
    // monitor off as in debug
    xfer(1'b1, SVM_CTRL_ADDR, 32'h0);
    setmv(12'hA8C);
    rd(SVM_CTRL_ADDR, 32'h9, "disabled reads high");
    xfer(1'b1, SVM_CTRL_ADDR, 32'h1);
    rd(SVM_CTRL_ADDR, 32'h8, "flag cleared");
    chk({31'h0, irq}, 32'h0, "rise masked");
    // a byte-sized write is not decoded and leaves the register alone
    @(posedge clk);
    hsize <= 3'h0;
    xfer(1'b1, SVM_CTRL_ADDR, 32'h6);
    hsize <= SVM_HSIZE_WORD;
    rd(SVM_CTRL_ADDR, 32'h8, "byte write ignored");
    // random supply levels and trip choices
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      setmv(12'hCE4);
      xfer(1'b1, SVM_CTRL_ADDR, {29'h0, lfsr_q[9], 2'h3});
      setmv(12'hA8C + {3'h0, lfsr_q[8:0]});
      c = exp_cmp(lfsr_q[9], mv);
      rd(SVM_CTRL_ADDR, {28'h0, c, lfsr_q[9], 1'b1, ~c}, "random trip");
      chk({31'h0, tp}, {31'h0, lfsr_q[9]}, "random select pin");
    end
    complete_run();
  end
endmodule
`default_nettype wire

// File: verilog/svm_pkg.sv
// supply monitor package: register map, field layout, reset values
package svm_pkg;

  // ===========================================================
  // register byte addresses
  localparam logic [31:0] SVM_CTRL_ADDR = 32'hFFFF0440;
  localparam logic [31:0] SVM_ISTS_ADDR = 32'hFFFF0444;
  localparam logic [31:0] SVM_IMSK_ADDR = 32'hFFFF0448;

  // ===========================================================
  // control register fields
  localparam int SVM_FLAG_BIT = 0;
  localparam int SVM_EN_BIT   = 1;
  localparam int SVM_TP_BIT   = 2;
  localparam int SVM_CMP_BIT  = 3;
  localparam int SVM_CTRL_W   = 16;
  localparam logic [15:0] SVM_CTRL_RST = 16'h0008;

  // ===========================================================
  // event status bits and reset values
  localparam int SVM_EV_LOW   = 0;
  localparam int SVM_EV_OK    = 1;
  localparam int SVM_EV_W     = 2;
  localparam logic [1:0] SVM_EV_RST = 2'h0;

  // ===========================================================
  // bus encodings
  localparam logic [1:0] SVM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SVM_HSIZE_WORD    = 3'h2;
  localparam logic       SVM_HRESP_OKAY    = 1'h0;

  // address phase captured for the data phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } svm_aphase_t;

  // control state held by software
  typedef struct packed {
    logic tp;
    logic en;
  } svm_ctrl_t;

endpackage

// File: verilog/svm_top.sv
// supply monitor control/status block with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none

module svm_top
  import svm_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        comparator_in,
  output logic             monitor_enable_out,
  output logic             threshold_select_out,
  output logic             low_supply_flag_out,
  output logic             irq_out
);

  // ===========================================================
  // comparator synchroniser
  logic sync1_q;
  logic sync2_q;
  logic sync1_d;
  logic sync2_d;

  // first stage feeds only the second; the pin is asynchronous
  always_comb begin
    sync1_d = comparator_in;
    sync2_d = sync1_q;
  end

  // resets to supply good so a release never fakes a low episode
  // two-flop synchroniser
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ===========================================================
  // bus address phase
  svm_aphase_t ap_q;
  svm_aphase_t ap_d;
  logic        take;

  // only whole-word transfers reach the strobes (read data ignores size); others still answer OKAY
  always_comb begin
    take     = hsel_in & hready_in & (htrans_in == SVM_HTRANS_NONSEQ);
    ap_d     = '0;
    ap_d.valid = take & (hsize_in == SVM_HSIZE_WORD);
    ap_d.write = hwrite_in;
    ap_d.addr  = haddr_in;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ap_q <= '0;
    end else begin
      ap_q <= ap_d;
    end
  end

  // zero wait states, never an error
  // limitation: a read right behind a write to the same register
  // returns the value from before that write
  assign hreadyout_out = 1'b1;
  assign hresp_out     = SVM_HRESP_OKAY;

  logic wr_ctrl;
  logic rd_ists;
  logic rd_any;
  logic wr_imsk;

  // data-phase strobes
  always_comb begin
    wr_ctrl = ap_q.valid & ap_q.write & (ap_q.addr == SVM_CTRL_ADDR);
    wr_imsk = ap_q.valid & ap_q.write & (ap_q.addr == SVM_IMSK_ADDR);
    rd_ists = ap_q.valid & ~ap_q.write & (ap_q.addr == SVM_ISTS_ADDR);
    rd_any  = ap_q.valid & ~ap_q.write;
  end

  // ===========================================================
  // control, comparator status and low supply flag
  svm_ctrl_t ctrl_q;
  svm_ctrl_t ctrl_d;
  logic      flag_q;
  logic      flag_d;
  logic      armed_q;
  logic      armed_d;
  logic      cmp_status;
  logic      flag_set;
  logic      flag_clr;

  // powered-down monitor reads as supply good
  assign cmp_status = ~ctrl_q.en | sync2_q;

  always_comb begin
    ctrl_d  = ctrl_q;
    flag_d  = flag_q;
    armed_d = armed_q;
    if (wr_ctrl) begin
      ctrl_d.tp = hwdata_in[SVM_TP_BIT];
      ctrl_d.en = hwdata_in[SVM_EN_BIT];
    end
    // set while status low and armed
    flag_set = ~cmp_status & armed_q;
    // write one clears only with status high
    flag_clr = wr_ctrl & hwdata_in[SVM_FLAG_BIT] & cmp_status;
    // set and clear are disjoint since they need opposite status
    if (flag_set) begin
      flag_d = 1'b1;
    end else if (flag_clr) begin
      flag_d = 1'b0;
    end
    // one interrupt per low episode, rearm when high
    if (flag_set) begin
      armed_d = 1'b0;
    end else if (cmp_status) begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q  <= '0;
      flag_q  <= SVM_CTRL_RST[SVM_FLAG_BIT];
      armed_q <= 1'b1;
    end else begin
      ctrl_q  <= ctrl_d;
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  assign monitor_enable_out   = ctrl_q.en;
  assign threshold_select_out = ctrl_q.tp;
  // flag is the interrupt controller's source line
  assign low_supply_flag_out  = flag_q;

  // ===========================================================
  // event status (read clears) and mask
  logic [SVM_EV_W-1:0] ists_q;
  logic [SVM_EV_W-1:0] ists_d;
  logic [SVM_EV_W-1:0] imsk_q;
  logic [SVM_EV_W-1:0] imsk_d;
  logic [SVM_EV_W-1:0] ev;
  logic                cmp_prev_q;

  // a new event in the clearing read cycle survives
  // set wins so no event is lost between the read and the clear
  always_comb begin
    ev            = '0;
    ev[SVM_EV_LOW] = flag_set;
    ev[SVM_EV_OK]  = cmp_status & ~cmp_prev_q;
    ists_d = (rd_ists ? '0 : ists_q) | ev;
    imsk_d = wr_imsk ? hwdata_in[SVM_EV_W-1:0] : imsk_q;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ists_q     <= SVM_EV_RST;
      imsk_q     <= SVM_EV_RST;
      cmp_prev_q <= 1'b1;
    end else begin
      ists_q     <= ists_d;
      imsk_q     <= imsk_d;
      cmp_prev_q <= cmp_status;
    end
  end

  assign irq_out = |(ists_q & imsk_q);

  // ===========================================================
  // read data
  logic [SVM_CTRL_W-1:0] ctrl_view;
  logic [31:0]           rdata_d;
  logic [31:0]           rdata_q;

  always_comb begin
    ctrl_view               = '0;
    ctrl_view[SVM_FLAG_BIT] = flag_q;
    ctrl_view[SVM_EN_BIT]   = ctrl_q.en;
    ctrl_view[SVM_TP_BIT]   = ctrl_q.tp;
    ctrl_view[SVM_CMP_BIT]  = cmp_status;
    rdata_d = 32'h00000000;
    // address phase is decoded so data stands in the data phase
    if (take & ~hwrite_in) begin
      case (haddr_in)
        SVM_CTRL_ADDR: rdata_d = {16'h0000, ctrl_view};
        SVM_ISTS_ADDR: rdata_d = {30'h0, ists_q | ev};
        SVM_IMSK_ADDR: rdata_d = {30'h0, imsk_q};
        default:       rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_out = rdata_q;

  // ===========================================================
  // checks

  // reset value of the control view
  AST_CTRL_RESET: assert property (@(posedge ref_clk_in)
    $fell(reset_in) |-> (ctrl_view == SVM_CTRL_RST))
    else $error("control view not at reset value");

  AST_CMP_OFF: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !monitor_enable_out |-> ctrl_view[SVM_CMP_BIT])
    else $error("comparator status low while monitor off");

  // pin change reaches status two cycles later
  AST_SYNC: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (ctrl_q.en && $stable(ctrl_q.en)) ##0 1 |->
      ##2 (sync2_q == $past(comparator_in, 2)))
    else $error("synchroniser latency wrong");

  // flag rises the cycle after armed low status
  AST_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!cmp_status && armed_q) |=> low_supply_flag_out)
    else $error("flag not set on low supply");

  // flag never clears while status low
  AST_NO_CLR_LOW: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ($past(low_supply_flag_out) && !$past(cmp_status)) |-> low_supply_flag_out)
    else $error("flag cleared while supply low");

  // write one with status high clears next cycle
  AST_CLR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (wr_ctrl && hwdata_in[SVM_FLAG_BIT] && cmp_status) |=> !low_supply_flag_out)
    else $error("flag not cleared by write one");

  // write zero leaves the flag alone
  AST_W0: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (wr_ctrl && !hwdata_in[SVM_FLAG_BIT] && low_supply_flag_out) |=> low_supply_flag_out)
    else $error("write zero changed flag");

  // no second low event while status stays low
  AST_NO_RESET: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!cmp_status && $past(!cmp_status)) |-> !ev[SVM_EV_LOW])
    else $error("low event repeated without recovery");

  // first low cycle of an episode raises the event
  AST_LOW_EV: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!cmp_status && $past(cmp_status)) |-> ev[SVM_EV_LOW])
    else $error("low supply event missing");

  AST_CTRL_WR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_ctrl |=> (monitor_enable_out == $past(hwdata_in[SVM_EN_BIT])) &&
      (threshold_select_out == $past(hwdata_in[SVM_TP_BIT])))
    else $error("control write not applied");

  AST_SRC: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (ap_q.valid && !ap_q.write && ap_q.addr == SVM_CTRL_ADDR) |->
      (hrdata_out[SVM_FLAG_BIT] == $past(low_supply_flag_out)))
    else $error("read flag differs from source line");

  // interrupt level follows masked status
  AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (ists_q[SVM_EV_LOW] && imsk_q[SVM_EV_LOW]) |-> irq_out)
    else $error("unmasked event without interrupt");

endmodule

`default_nettype wire
